// *** dv/control_command_ack_and_adjust_bench.sv ***
module control_command_ack_and_adjust_bench;
    timeunit 1ns;
    timeprecision 1ps;

    // =========================================================
    // signals
    // =========================================================
    logic        clk, rst, ce, wbCyc, wbStb, wbWe, wbAck, irq;
    logic        laserEnable, errorReport, faultActive;
    logic [3:0]  wbSel;
    logic [31:0] wbAdr, wbDatIn, wbDatOut, rawPosition, intensity;
    logic [31:0] speed, serialData, position, rdVal;
    logic [31:0] src [3];
    int          failures;
    int          checkCount;

    wb_master_model master (.clk(clk), .cyc(wbCyc), .stb(wbStb), .we(wbWe),
        .sel(wbSel), .adr(wbAdr), .dat(wbDatIn), .datIn(wbDatOut),
        .ack(wbAck));

    control_command_ack_and_adjust dut (.clk(clk), .rst(rst), .ce(ce),
        .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbSel(wbSel),
        .wbAdr(wbAdr), .wbDatIn(wbDatIn), .wbDatOut(wbDatOut),
        .wbAck(wbAck), .rawPosition(rawPosition), .intensity(intensity),
        .speed(speed), .faultActive(faultActive), .serialData(serialData),
        .position(position), .laserEnable(laserEnable),
        .errorReport(errorReport), .irq(irq));

    // =========================================================
    // tasks
    // =========================================================
    task automatic conclude();
        $display("checks %0d mismatches %0d", checkCount, failures);
        if (failures == 0 && checkCount > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        logic [31:0] q;
        logic        ok;
        master.access(1'b1, {24'h000000, a}, d, s, q, ok);
        if (!ok)
        begin
            failures++;
            conclude();
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        logic ok;
        master.access(1'b0, {24'h000000, a}, 32'h0, 4'hf, rdVal, ok);
        if (!ok)
        begin
            failures++;
            conclude();
        end
        check(rdVal, exp);
    endtask

    // raise a command, read its ack, release it and see the ack drop
    task automatic pulse(input logic [7:0] c, input logic [7:0] expAck);
        wr(cmd_ack_pkg::ADDR_COMMAND, {24'h000000, c}, 4'h1);
        rdchk(cmd_ack_pkg::ADDR_ACK, {24'h000000, expAck});
        wr(cmd_ack_pkg::ADDR_COMMAND, 32'h00000000, 4'h1);
        rdchk(cmd_ack_pkg::ADDR_ACK, 32'h00000000);
    endtask

    task automatic settle();
        repeat (3) @(posedge clk);
    endtask

    // =========================================================
    // clock and sequence
    // =========================================================
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial
    begin
        rst = 1'b1;
        ce = 1'b1;
        rawPosition = 32'h00000100;
        intensity = 32'h00002222;
        speed = 32'h00003333;
        faultActive = 1'b0;
        failures = 0;
        checkCount = 0;
        src[0] = 32'h00000100;
        src[1] = 32'h00002222;
        src[2] = 32'h00003333;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        settle();
        check(32'(laserEnable), 32'h1);
        check(32'(irq), 32'h0);
        check(position, src[0]);
        rdchk(cmd_ack_pkg::ADDR_CFG_ID, {16'h0000, cmd_ack_pkg::CFG_ID_ADJUST,
              cmd_ack_pkg::CFG_ID_COMMAND});
        rdchk(cmd_ack_pkg::ADDR_PARAM, 32'h00000000);
        wr(8'h30, 32'hffffffff, 4'hf);
        rdchk(8'h30, 32'h00000000);
        for (int i = 0; i < 3; i++)
        begin
            wr(cmd_ack_pkg::ADDR_PARAM, 32'(i), 4'h1);
            settle();
            check(serialData, src[i]);
        end
        // adjust values stay inside zero to measuring length
        wr(cmd_ack_pkg::ADDR_ADJ_VALUE, 32'h00001234, 4'hf);
        pulse(8'h10, 8'h10);
        check(position, 32'h00001234);
        wr(cmd_ack_pkg::ADDR_ADJ_VALUE, 32'h00005555, 4'h3);
        pulse(8'h10, 8'h10);
        check(position, 32'h00001234);
        wr(cmd_ack_pkg::ADDR_ADJ_VALUE, 32'h00000000, 4'hf);
        pulse(8'h10, 8'h10);
        check(position, 32'h00000000);
        wr(cmd_ack_pkg::ADDR_PRESET, 32'h00000077, 4'hf);
        pulse(8'h20, 8'h20);
        check(position, 32'h00000077);
        pulse(8'h40, 8'h40);
        check(position, src[0]);
        rdchk(cmd_ack_pkg::ADDR_POSITION, src[0]);
        pulse(8'h0c, 8'h00);
        pulse(8'h01, 8'h01);
        check(32'(laserEnable), 32'h0);
        pulse(8'h02, 8'h02);
        check(32'(laserEnable), 32'h1);
        for (int k = 16; k < 18; k++)
        begin
            wr(cmd_ack_pkg::ADDR_PARAM, 32'h1 << k, 4'hf);
            pulse(8'h01, 8'h01);
            check(32'(laserEnable), 32'h1);
        end
        wr(cmd_ack_pkg::ADDR_PARAM, 32'h00000000, 4'hf);
        rdchk(cmd_ack_pkg::ADDR_STATUS, 32'h00000001);
        rdchk(cmd_ack_pkg::ADDR_IRQ_STAT, 32'h00000001);
        wr(cmd_ack_pkg::ADDR_IRQ_STAT, 32'h00000003, 4'h1);
        wr(cmd_ack_pkg::ADDR_IRQ_MASK, 32'h00000002, 4'h1);
        check(32'(irq), 32'h0);
        @(posedge clk);
        faultActive <= 1'b1;
        settle();
        check(32'(errorReport), 32'h1);
        check(32'(irq), 32'h1);
        rdchk(cmd_ack_pkg::ADDR_IRQ_STAT, 32'h00000002);
        wr(cmd_ack_pkg::ADDR_IRQ_MASK, 32'h00000000, 4'h1);
        check(32'(irq), 32'h0);
        wr(cmd_ack_pkg::ADDR_IRQ_MASK, 32'h00000002, 4'h1);
        wr(cmd_ack_pkg::ADDR_IRQ_STAT, 32'h00000002, 4'h1);
        check(32'(irq), 32'h0);
        // fault still present, so the report stays set through the clear
        pulse(8'h80, 8'h80);
        check(32'(errorReport), 32'h1);
        @(posedge clk);
        faultActive <= 1'b0;
        settle();
        check(32'(errorReport), 32'h1);
        pulse(8'h80, 8'h80);
        check(32'(errorReport), 32'h0);
        wr(cmd_ack_pkg::ADDR_PARAM, 32'h00000100, 4'h2);
        @(posedge clk);
        faultActive <= 1'b1;
        settle();
        check(32'(errorReport), 32'h1);
        faultActive <= 1'b0;
        settle();
        check(32'(errorReport), 32'h0);
        // clock enable low freezes the report despite a new fault
        ce <= 1'b0;
        faultActive <= 1'b1;
        settle();
        check(32'(errorReport), 32'h0);
        ce <= 1'b1;
        settle();
        check(32'(errorReport), 32'h1);
        conclude();
    end
endmodule // control_command_ack_and_adjust_bench

// *** dv/wb_master_model.sv ***
module wb_master_model
(
    // clocking
    input  wire logic        clk,
    // wishbone master side
    output logic             cyc,
    output logic             stb,
    output logic             we,
    output logic      [3:0]  sel,
    output logic      [31:0] adr,
    output logic      [31:0] dat,
    // slave answer
    input  wire logic [31:0] datIn,
    input  wire logic        ack
);
    timeunit 1ns;
    timeprecision 1ps;

    // =========================================================
    // idle bus
    // =========================================================
    initial
    begin
        cyc = 1'b0;
        stb = 1'b0;
        we  = 1'b0;
        sel = 4'h0;
        adr = 32'h00000000;
        dat = 32'h00000000;
    end

    // =========================================================
    // one classic cycle, held until ack is sampled or 16 clocks pass without it
    // =========================================================
    // a whole word goes in one cycle, so the value stays consistent
    task automatic access(input logic w, input logic [31:0] a,
                          input logic [31:0] d, input logic [3:0] s,
                          output logic [31:0] q, output logic ok);
        int n;
        ok = 1'b0;
        q = 32'h00000000;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        sel <= s;
        for (n = 0; n < 16; n++)
        begin
            @(posedge clk);
            if (ack === 1'b1)
            begin
                ok = 1'b1;
                q = datIn;
                break;
            end
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        // released lines flip so a stale word cannot look valid
        dat <= ~d;
        adr <= ~a;
    endtask
endmodule // wb_master_model

// *** verilog/cmd_ack_pkg.sv ***
package cmd_ack_pkg;

    // =========================================================
    // register map (word offsets as byte addresses)
    // =========================================================
    localparam logic [7:0] ADDR_COMMAND   = 8'h00;
    localparam logic [7:0] ADDR_ACK       = 8'h04;
    localparam logic [7:0] ADDR_ADJ_VALUE = 8'h08;
    localparam logic [7:0] ADDR_PARAM     = 8'h0c;
    localparam logic [7:0] ADDR_PRESET    = 8'h10;
    localparam logic [7:0] ADDR_STATUS    = 8'h14;
    localparam logic [7:0] ADDR_IRQ_STAT  = 8'h18;
    localparam logic [7:0] ADDR_IRQ_MASK  = 8'h1c;
    localparam logic [7:0] ADDR_POSITION  = 8'h20;
    localparam logic [7:0] ADDR_CFG_ID    = 8'h24;

    // =========================================================
    // command / acknowledge bit positions
    // =========================================================
    localparam int BIT_LASER_OFF = 0;
    localparam int BIT_LASER_ON  = 1;
    localparam int BIT_ADJUST    = 4;
    localparam int BIT_PRESET    = 5;
    localparam int BIT_CLR_PRE   = 6;
    localparam int BIT_CLR_ERR   = 7;
    localparam logic [7:0] ACK_USED_MASK = 8'hf3;

    // =========================================================
    // parameter field positions within ADDR_PARAM
    // =========================================================
    localparam int PRM_SERIAL_LSB = 0;
    localparam int PRM_QUIT_LSB   = 8;
    localparam int PRM_PINFN_BIT  = 16;
    localparam int PRM_AUTOLD_BIT = 17;

    // =========================================================
    // values and reset defaults
    // =========================================================
    localparam logic [7:0] SERIAL_POSITION  = 8'h00;
    localparam logic [7:0] SERIAL_INTENSITY = 8'h01;
    localparam logic [7:0] SERIAL_SPEED     = 8'h02;
    localparam logic [7:0] QUIT_MANUAL      = 8'h00;
    localparam logic [7:0] QUIT_AUTO        = 8'h01;
    localparam logic [7:0] CFG_ID_ADJUST    = 8'he1;
    localparam logic [7:0] CFG_ID_COMMAND   = 8'h30;
    localparam logic [31:0] ZERO32          = 32'h00000000;
    localparam logic [7:0]  ZERO8           = 8'h00;

    // irq status bit positions
    localparam int IRQ_CMD_DONE  = 0;
    localparam int IRQ_FAULT_SET = 1;

    // =========================================================
    // carriers
    // =========================================================
    typedef struct packed {
        logic [7:0]  serialSel;
        logic [7:0]  quitMode;
        logic        pinLaserSwitch;
        logic        autoLaserOff;
    } param_t;

    typedef struct packed {
        logic [31:0] adr;
        logic [31:0] dat;
        logic [3:0]  sel;
        logic        we;
        logic        cyc;
        logic        stb;
    } wb_req_t;

endpackage

// *** verilog/control_command_ack_and_adjust.sv ***
// Functional notes
// R1: serial output source chosen by parameter, default 0: position, intensity, speed.
// R2: 32-bit adjust value carried as one consistent double word.
// R3: adjust command makes reported position equal the held adjust value.
// R4: master keeps adjust value between zero and measuring length.
// R5: adjust value may change and be triggered any time in exchange.
// R6: adjustment module configuration identifier is 0xe1.
// R7: command byte in, acknowledge byte out, bit-coded, one means active.
// R8: ack bits: 0 off, 1 on, 4 adjust, 5 preset, 6 clear, 7 error.
// R9: command bit 0 switches laser off.
// R10: command bit 1 switches laser on.
// R11: laser commands ignored when pin switches laser or auto-off set.
// R12: command bit 4 adjusts position from the adjust double word.
// R13: command bit 5 adjusts position to stored preset words.
// R14: command bit 6 deletes offset, raw physical position reported.
// R15: manual mode, bit 7 clears error; persisting fault sets it again.
// R16: command module configuration identifier is 0x30.
// R17: quit parameter default 0 manual; 1 clears error once fault gone.
// R18: ack rises after command done, holds while set, drops on release.
//
// The Wishbone interface to the registers and the register addresses were decided locally.
module control_command_ack_and_adjust
(
    // clocking
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    // wishbone slave
    input  wire logic        wbCyc,
    input  wire logic        wbStb,
    input  wire logic        wbWe,
    input  wire logic [3:0]  wbSel,
    input  wire logic [31:0] wbAdr,
    input  wire logic [31:0] wbDatIn,
    output logic      [31:0] wbDatOut,
    output logic             wbAck,
    // measurement sources
    input  wire logic [31:0] rawPosition,
    input  wire logic [31:0] intensity,
    input  wire logic [31:0] speed,
    input  wire logic        faultActive,
    // device outputs
    output logic      [31:0] serialData,
    output logic      [31:0] position,
    output logic             laserEnable,
    output logic             errorReport,
    output logic             irq
);

    // =========================================================
    // bus decode
    // =========================================================
    logic        access;
    logic [7:0]  commandOutByte;
    logic [31:0] adjustValueOutDword;
    logic [31:0] presetValue;
    logic [7:0]  ackInByte;
    logic [1:0]  irqStatus;
    logic [1:0]  irqMask;
    cmd_ack_pkg::param_t prm;

    wb_slave_if u_wb
    (
        .clk    (clk),
        .rst    (rst),
        .ce     (ce),
        .cyc    (wbCyc),
        .stb    (wbStb),
        .ack    (wbAck),
        .access (access)
    );

    wire        wrEn      = access && wbWe;
    wire [7:0]  regAdr    = wbAdr[7:0];
    wire        wrCommand = wrEn && regAdr == cmd_ack_pkg::ADDR_COMMAND;
    wire        wrAdjust  = wrEn && regAdr == cmd_ack_pkg::ADDR_ADJ_VALUE;
    wire        wrParam   = wrEn && regAdr == cmd_ack_pkg::ADDR_PARAM;
    wire        wrPreset  = wrEn && regAdr == cmd_ack_pkg::ADDR_PRESET;
    wire        wrIrqStat = wrEn && regAdr == cmd_ack_pkg::ADDR_IRQ_STAT;
    wire        wrIrqMask = wrEn && regAdr == cmd_ack_pkg::ADDR_IRQ_MASK;

    // byte-lane merge; adjust word is only updated as a whole unit
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nu,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (sel[i])
                r[i*8 +: 8] = nu[i*8 +: 8];
        return r;
    endfunction

    wire [31:0] paramWord = {14'h0000, prm.autoLaserOff, prm.pinLaserSwitch,
                             prm.quitMode, prm.serialSel};
    wire [31:0] next_param = merge(paramWord, wbDatIn, wbSel);

    // =========================================================
    // software registers
    // =========================================================
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            commandOutByte      <= cmd_ack_pkg::ZERO8;
            adjustValueOutDword <= cmd_ack_pkg::ZERO32;
            presetValue         <= cmd_ack_pkg::ZERO32;
            prm.serialSel       <= cmd_ack_pkg::SERIAL_POSITION;  // R1
            prm.quitMode        <= cmd_ack_pkg::QUIT_MANUAL;      // R17
            prm.pinLaserSwitch  <= 1'b0;
            prm.autoLaserOff    <= 1'b0;
            irqMask             <= 2'h0;
        end
        else if (ce)
        begin
            if (wrCommand && wbSel[0])
                commandOutByte <= wbDatIn[7:0];  // R7
            // whole word or nothing keeps the value consistent
            if (wrAdjust && wbSel == 4'hf)
                adjustValueOutDword <= wbDatIn;  // R2 R5
            if (wrPreset)
                presetValue <= merge(presetValue, wbDatIn, wbSel);
            if (wrParam)
            begin
                prm.serialSel      <= next_param[cmd_ack_pkg::PRM_SERIAL_LSB +: 8];
                prm.quitMode       <= next_param[cmd_ack_pkg::PRM_QUIT_LSB +: 8];
                prm.pinLaserSwitch <= next_param[cmd_ack_pkg::PRM_PINFN_BIT];
                prm.autoLaserOff   <= next_param[cmd_ack_pkg::PRM_AUTOLD_BIT];
            end
            if (wrIrqMask && wbSel[0])
                irqMask <= wbDatIn[1:0];
        end
    end

    // =========================================================
    // command execution
    // =========================================================
    // a command runs once on the rising edge of its bit
    logic [7:0] cmdSeen;
    wire  [7:0] cmdRise = commandOutByte & ~cmdSeen & cmd_ack_pkg::ACK_USED_MASK;
    wire        laserLocked = prm.pinLaserSwitch || prm.autoLaserOff;  // R11

    wire doLaserOff = cmdRise[cmd_ack_pkg::BIT_LASER_OFF] && !laserLocked; // R9
    wire doLaserOn  = cmdRise[cmd_ack_pkg::BIT_LASER_ON] && !laserLocked;  // R10
    wire doAdjust   = cmdRise[cmd_ack_pkg::BIT_ADJUST];   // R12
    wire doPreset   = cmdRise[cmd_ack_pkg::BIT_PRESET];   // R13
    wire doClear    = cmdRise[cmd_ack_pkg::BIT_CLR_PRE];  // R14
    wire quitManual = prm.quitMode == cmd_ack_pkg::QUIT_MANUAL;
    wire doClrErr   = cmdRise[cmd_ack_pkg::BIT_CLR_ERR] && quitManual; // R15

    // adjust wins over preset if both rise together
    wire        setTarget = doAdjust || doPreset;
    wire [31:0] target    = doAdjust ? adjustValueOutDword : presetValue; // R3

    offset_unit u_offset
    (
        .clk         (clk),
        .rst         (rst),
        .ce          (ce),
        .setTarget   (setTarget),
        .clearOffset (doClear),
        .target      (target),
        .rawPosition (rawPosition),
        .position    (position)
    );

    // ignored laser commands are still acknowledged as seen; only the
    // laser itself is left alone
    wire [7:0] done = {doClrErr | (cmdRise[cmd_ack_pkg::BIT_CLR_ERR] & !quitManual),
                       doClear, doPreset, doAdjust, 2'b00,
                       cmdRise[cmd_ack_pkg::BIT_LASER_ON],
                       cmdRise[cmd_ack_pkg::BIT_LASER_OFF]};
    wire [7:0] next_ack = (ackInByte | done) & commandOutByte; // R18

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cmdSeen     <= cmd_ack_pkg::ZERO8;
            ackInByte   <= cmd_ack_pkg::ZERO8;
            laserEnable <= 1'b1;
        end
        else if (ce)
        begin
            cmdSeen   <= commandOutByte;
            ackInByte <= next_ack & cmd_ack_pkg::ACK_USED_MASK;  // R8 R18
            if (doLaserOff)
                laserEnable <= 1'b0;  // R9
            else if (doLaserOn)
                laserEnable <= 1'b1;  // R10
        end
    end

    // =========================================================
    // error report
    // =========================================================
    // persisting fault keeps the report set, even in the cycle of a clear
    wire next_error = faultActive
                   || (errorReport && !doClrErr && quitManual); // R15 R17

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            errorReport <= 1'b0;
        else if (ce)
            errorReport <= next_error;
    end

    // =========================================================
    // serial content select
    // =========================================================
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            serialData <= cmd_ack_pkg::ZERO32;
        else if (ce)
        begin
            case (prm.serialSel)  // R1
                cmd_ack_pkg::SERIAL_INTENSITY: serialData <= intensity;
                cmd_ack_pkg::SERIAL_SPEED:     serialData <= speed;
                default:                       serialData <= position;
            endcase
        end
    end

    // =========================================================
    // interrupts
    // =========================================================
    wire [1:0] irqEvent = {next_error && !errorReport, |(next_ack & ~ackInByte)};
    wire [1:0] irqClr   = (wrIrqStat && wbSel[0]) ? wbDatIn[1:0] : 2'b00;

    // set wins over clear
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            irqStatus <= 2'h0;
        else if (ce)
            irqStatus <= (irqStatus & ~irqClr) | irqEvent;
    end

    assign irq = |(irqStatus & irqMask);

    // =========================================================
    // read mux
    // =========================================================
    wire [31:0] cfgIdWord = {16'h0000, cmd_ack_pkg::CFG_ID_ADJUST,
                             cmd_ack_pkg::CFG_ID_COMMAND};  // R6 R16
    wire [31:0] statusWord = {30'h00000000, errorReport, laserEnable};
    logic [31:0] rdData;

    always_comb
    begin
        case (regAdr)
            cmd_ack_pkg::ADDR_COMMAND:   rdData = {24'h000000, commandOutByte};
            cmd_ack_pkg::ADDR_ACK:       rdData = {24'h000000, ackInByte};
            cmd_ack_pkg::ADDR_ADJ_VALUE: rdData = adjustValueOutDword;
            cmd_ack_pkg::ADDR_PARAM:     rdData = paramWord;
            cmd_ack_pkg::ADDR_PRESET:    rdData = presetValue;
            cmd_ack_pkg::ADDR_STATUS:    rdData = statusWord;
            cmd_ack_pkg::ADDR_IRQ_STAT:  rdData = {30'h00000000, irqStatus};
            cmd_ack_pkg::ADDR_IRQ_MASK:  rdData = {30'h00000000, irqMask};
            cmd_ack_pkg::ADDR_POSITION:  rdData = position;
            cmd_ack_pkg::ADDR_CFG_ID:    rdData = cfgIdWord;
            default:                     rdData = cmd_ack_pkg::ZERO32;
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            wbDatOut <= cmd_ack_pkg::ZERO32;
        else if (ce && access)
            wbDatOut <= rdData;
    end

    // =========================================================
    // assertions
    // =========================================================
    sequence adjRise_s;
        ce && doAdjust && !doClear;
    endsequence

    sequence rawSteady_s;
        ce && rawPosition == $past(rawPosition);
    endsequence

    // adjust wins over preset, so only a lone preset is checked here
    sequence presetRise_s;
        ce && doPreset && !doAdjust && !doClear;
    endsequence

    ack_drop_a: assert property (@(posedge clk) disable iff (rst) // R18
        ce && !commandOutByte[cmd_ack_pkg::BIT_ADJUST]
        |=> !ackInByte[cmd_ack_pkg::BIT_ADJUST])
        else $error("adjust ack held without command");

    ack_rise_a: assert property (@(posedge clk) disable iff (rst) // R8
        ce && doAdjust && commandOutByte[cmd_ack_pkg::BIT_ADJUST]
        |=> ackInByte[cmd_ack_pkg::BIT_ADJUST])
        else $error("adjust ack missing");

    unused_ack_a: assert property (@(posedge clk) disable iff (rst) // R8
        ackInByte[3:2] == 2'b00)
        else $error("unused ack bits set");

    laser_off_a: assert property (@(posedge clk) disable iff (rst) // R9
        ce && doLaserOff |=> !laserEnable)
        else $error("laser not switched off");

    laser_lock_a: assert property (@(posedge clk) disable iff (rst) // R11
        ce && laserLocked |=> laserEnable == $past(laserEnable))
        else $error("laser changed while locked");

    adjust_pos_a: assert property (@(posedge clk) disable iff (rst) // R3
        adjRise_s ##1 rawSteady_s
        |=> position == $past(adjustValueOutDword, 2))
        else $error("position not adjusted");

    serial_sel_a: assert property (@(posedge clk) disable iff (rst) // R1
        ce && prm.serialSel == cmd_ack_pkg::SERIAL_SPEED
        |=> serialData == $past(speed))
        else $error("serial source wrong");

    fault_back_a: assert property (@(posedge clk) disable iff (rst) // R15
        ce && faultActive |=> errorReport)
        else $error("fault not reported");

    auto_quit_a: assert property (@(posedge clk) disable iff (rst) // R17
        ce && !quitManual && !faultActive |=> !errorReport)
        else $error("auto quit kept error");

    bus_ack_a: assert property (@(posedge clk) disable iff (rst)
        ce && wbAck |=> !wbAck)
        else $error("ack longer than one cycle");

    laser_on_a: assert property (@(posedge clk) disable iff (rst) // R10
        ce && doLaserOn |=> laserEnable)
        else $error("laser not switched on");

    preset_pos_a: assert property (@(posedge clk) disable iff (rst) // R13
        presetRise_s ##1 rawSteady_s
        |=> position == $past(presetValue, 2))
        else $error("position not preset");

    clear_pos_a: assert property (@(posedge clk) disable iff (rst) // R14
        ce && doClear ##1 ce
        |=> position == $past(rawPosition))
        else $error("offset not cleared");

    clear_err_a: assert property (@(posedge clk) disable iff (rst) // R15
        ce && doClrErr && !faultActive |=> !errorReport)
        else $error("error report not cleared");

endmodule // control_command_ack_and_adjust

// *** verilog/offset_unit.sv ***
module offset_unit
(
    // clocking
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    // control
    input  wire logic        setTarget,
    input  wire logic        clearOffset,
    input  wire logic [31:0] target,
    // sensor
    input  wire logic [31:0] rawPosition,
    // result
    output logic      [31:0] position
);

    logic [31:0] offset;
    wire  [31:0] next_offset = target - rawPosition;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            offset <= cmd_ack_pkg::ZERO32;
        else if (ce && clearOffset)
            offset <= cmd_ack_pkg::ZERO32;
        else if (ce && setTarget)
            offset <= next_offset;
    end

    // reported position follows raw position plus the held offset
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            position <= cmd_ack_pkg::ZERO32;
        else if (ce)
            position <= rawPosition + offset;
    end

endmodule // offset_unit

// *** verilog/wb_slave_if.sv ***
module wb_slave_if
(
    // clocking
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    // wishbone request
    input  wire logic        cyc,
    input  wire logic        stb,
    // handshake
    output logic             ack,
    output logic             access
);

    // one ack per request; ack falls the cycle after it was given
    assign access = cyc && stb && !ack;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            ack <= 1'b0;
        else if (ce)
            ack <= access;
    end

endmodule // wb_slave_if
